/* File: design/mtc_consts.vh */
`ifndef MTC_CONSTS_VH
`define MTC_CONSTS_VH
// Register indices on the plain register port.
`define MTC_ADDR_W        3
`define MTC_REG_CTRL      3'h0
`define MTC_REG_COUNT     3'h1
`define MTC_REG_RELOAD    3'h2
`define MTC_REG_PWMCAP    3'h3
`define MTC_REG_STATUS    3'h4
// Control register fields.
`define MTC_CTRL_W        16
`define MTC_CTRL_RESET    16'h0000
// Reserved control bits read back as zero.
`define MTC_CTRL_MASK     16'h7f3f
`define MTC_EN_BIT        0
`define MTC_MODE_LSB      1
`define MTC_MODE_MSB      3
`define MTC_POL_BIT       4
`define MTC_OUTEN_BIT     5
`define MTC_PRE_LSB       8
`define MTC_PRE_MSB       14
// Mode codes.
`define MTC_MODE_COUNTER  3'h0
`define MTC_MODE_PWM      3'h1
`define MTC_MODE_CAPTURE  3'h2
`define MTC_MODE_COMPARE  3'h3
`define MTC_MODE_GATED    3'h4
// Counter values.
`define MTC_CNT_RESET     16'h0000
`define MTC_CNT_RESTART   16'h0001
`define MTC_RELOAD_RESET  16'hffff
`define MTC_PWM_RESET     16'h0000
`define MTC_PRE_W         7
`define MTC_PRE_ZERO      7'h00
`define MTC_PRE_ONE       7'h01
`endif

/* File: design/mtc_input_sync.v */
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser plus edge and level qualification of the timer input.
module mtc_input_sync (
   input  wire mclk,      // System clock.
   input  wire reset_n,   // Synchronous reset, active low.
   input  wire clkEn,     // Clock enable.
   input  wire pinIn,     // Raw timer input pin.
   input  wire polarity,  // 1 selects rising edge / high active.
   output wire active,    // Input at its active level.
   output wire assertEdge,   // One-cycle pulse on the selected edge.
   output wire deassertEdge  // One-cycle pulse on the opposite edge.
);
   reg meta_q;
   reg sync_q;
   reg last_q;

   always @(posedge mclk) begin
      if (!reset_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else if (clkEn) begin
         meta_q <= pinIn;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign active       = sync_q == polarity;
   assign assertEdge   = clkEn & (sync_q == polarity) & (last_q != polarity);
   assign deassertEdge = clkEn & (sync_q != polarity) & (last_q == polarity);
endmodule
`default_nettype wire

/* File: design/mtc_timer.v */
// Notes on behaviour
// - Counter mode counts input edges; polarity bit picks rising or falling.
// - Counter mode bypasses the prescaler; one edge gives one count.
// - Counter mode at reload: interrupt, load 0001, count on, toggle enabled output.
// - In counter mode the polarity bit sets the output's initial level.
// - Counter, PWM, gated: written start count only for first pass; then 0001.
// - PWM counts prescaled clocks, toggles at PWM match, reloads with interrupt.
// - PWM polarity 1: output starts high, low at match, high at reload.
// - PWM polarity 0: output starts low, high at match, low at reload.
// - Capture mode copies count on selected edge, interrupts, keeps counting.
// - Capture mode interrupts at reload value and carries on counting.
// - Compare mode at compare value: interrupt, toggle enabled output, no reset.
// - Compare mode wraps FFFF to 0000 and keeps counting.
// - Gated mode counts prescaled clocks only while input is active.
// - Gated mode interrupts when the input deasserts and on reload.
// - Gated reload: interrupt, load 0001, toggle enabled output, continue.
// - Prescaler divides mclk by 1 to 128 in clocked modes.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "mtc_consts.vh"
module mtc_timer (
   input  wire        mclk,      // System clock, 10 MHz.
   input  wire        reset_n,   // Synchronous reset, active low.
   input  wire        clkEn,     // Freezes all state while low.
   input  wire [2:0]  regAddr,   // Register index.
   input  wire [15:0] regWdata,  // Write data.
   input  wire        regWr,     // Write strobe.
   input  wire        regRd,     // Read strobe.
   output reg  [15:0] regRdata,  // Read data, valid the cycle after regRd.
   input  wire        timerIn,   // External timer input pin.
   output reg         timerOut,  // Timer output pin level.
   output reg         timerIrq   // One-cycle timer interrupt pulse.
);
   reg  [15:0] ctrl_q;
   reg  [15:0] count_q;
   reg  [15:0] reload_q;
   reg  [15:0] pwmCap_q;
   reg  [6:0]  pre_q;
   reg         outLvl_q;
   reg         irqSeen_q;
   reg         capSeen_q;
   reg         timerOut_d;
   reg         irq_d;
   reg  [15:0] count_d;
   reg  [6:0]  pre_d;
   reg  [15:0] pwmCap_d;
   reg  [15:0] rdata_d;

   wire        enable   = ctrl_q[`MTC_EN_BIT];
   wire [2:0]  mode     = ctrl_q[`MTC_MODE_MSB:`MTC_MODE_LSB];
   wire        polarity = ctrl_q[`MTC_POL_BIT];
   wire        outEn    = ctrl_q[`MTC_OUTEN_BIT];
   wire [6:0]  preSel   = ctrl_q[`MTC_PRE_MSB:`MTC_PRE_LSB];
   wire        inActive;
   wire        inAssert;
   wire        inDeassert;

   mtc_input_sync uSync (
      .mclk         (mclk),
      .reset_n      (reset_n),
      .clkEn        (clkEn),
      .pinIn        (timerIn),
      .polarity     (polarity),
      .active       (inActive),
      .assertEdge   (inAssert),
      .deassertEdge (inDeassert)
   );

   wire isCounter = mode == `MTC_MODE_COUNTER;
   wire isPwm     = mode == `MTC_MODE_PWM;
   wire isCapture = mode == `MTC_MODE_CAPTURE;
   wire isCompare = mode == `MTC_MODE_COMPARE;
   wire isGated   = mode == `MTC_MODE_GATED;

   // The prescaler wraps at preSel; a field of zero divides by 128.
   wire preWrap = (pre_q + `MTC_PRE_ONE) == preSel;
   // Gated mode stops the prescaler as well as the counter.
   wire preRun  = enable & ~isCounter & (~isGated | inActive);
   wire tick    = isCounter ? (enable & inAssert) : (preRun & preWrap);
   wire atReload = count_q == reload_q;

   always @* begin
      count_d    = count_q;
      pre_d      = pre_q;
      pwmCap_d   = pwmCap_q;
      timerOut_d = outLvl_q;
      irq_d      = 1'b0;
      rdata_d    = 16'h0000;
      if (preRun) begin
         pre_d = preWrap ? `MTC_PRE_ZERO : pre_q + `MTC_PRE_ONE;
      end
      if (tick) begin
         case (mode)
            `MTC_MODE_COUNTER, `MTC_MODE_GATED: begin
               if (atReload) begin
                  irq_d   = 1'b1;
                  count_d = `MTC_CNT_RESTART;
                  if (outEn) begin
                     timerOut_d = ~outLvl_q;
                  end
               end else begin
                  count_d = count_q + 16'h0001;
               end
            end
            `MTC_MODE_PWM: begin
               if (atReload) begin
                  irq_d      = 1'b1;
                  count_d    = `MTC_CNT_RESTART;
                  timerOut_d = polarity;
               end else begin
                  count_d = count_q + 16'h0001;
                  if (count_q == pwmCap_q) begin
                     timerOut_d = ~polarity;
                  end
               end
            end
            `MTC_MODE_CAPTURE: begin
               count_d = count_q + 16'h0001;
               if (atReload) begin
                  irq_d = 1'b1;
               end
            end
            `MTC_MODE_COMPARE: begin
               count_d = count_q + 16'h0001;
               if (atReload) begin
                  irq_d = 1'b1;
                  if (outEn) begin
                     timerOut_d = ~outLvl_q;
                  end
               end
            end
            default: begin
               count_d = count_q;
            end
         endcase
      end
      if (enable & isCapture & inAssert) begin
         pwmCap_d = count_q;
         irq_d    = 1'b1;
      end
      if (enable & isGated & inDeassert) begin
         irq_d = 1'b1;
      end
      if (regRd) begin
         case (regAddr)
            `MTC_REG_CTRL:   rdata_d = ctrl_q & `MTC_CTRL_MASK;
            `MTC_REG_COUNT:  rdata_d = count_q;
            `MTC_REG_RELOAD: rdata_d = reload_q;
            `MTC_REG_PWMCAP: rdata_d = pwmCap_q;
            `MTC_REG_STATUS: rdata_d = {13'h0000, capSeen_q, irqSeen_q, outLvl_q};
            default:         rdata_d = 16'h0000;
         endcase
      end
   end

   always @(posedge mclk) begin
      if (!reset_n) begin
         ctrl_q    <= `MTC_CTRL_RESET;
         count_q   <= `MTC_CNT_RESET;
         reload_q  <= `MTC_RELOAD_RESET;
         pwmCap_q  <= `MTC_PWM_RESET;
         pre_q     <= `MTC_PRE_ZERO;
         outLvl_q  <= 1'b0;
         timerOut  <= 1'b0;
         timerIrq  <= 1'b0;
         irqSeen_q <= 1'b0;
         capSeen_q <= 1'b0;
         regRdata  <= 16'h0000;
      end else if (clkEn) begin
         count_q  <= count_d;
         pre_q    <= pre_d;
         pwmCap_q <= pwmCap_d;
         outLvl_q <= timerOut_d;
         timerOut <= timerOut_d;
         timerIrq <= irq_d;
         regRdata <= rdata_d;
         // Sticky status: a new event wins over the read that clears it.
         irqSeen_q <= irq_d | (irqSeen_q & ~(regRd & regAddr == `MTC_REG_STATUS));
         capSeen_q <= (enable & isCapture & inAssert)
                    | (capSeen_q & ~(regRd & regAddr == `MTC_REG_STATUS));
         if (regWr) begin
            case (regAddr)
               `MTC_REG_CTRL: begin
                  ctrl_q <= regWdata;
                  // A disabled timer shows the polarity bit as its start level.
                  if (!regWdata[`MTC_EN_BIT]) begin
                     outLvl_q <= regWdata[`MTC_POL_BIT];
                     timerOut <= regWdata[`MTC_POL_BIT];
                     pre_q    <= `MTC_PRE_ZERO;
                  end
               end
               `MTC_REG_COUNT:  count_q  <= regWdata;
               `MTC_REG_RELOAD: reload_q <= regWdata;
               `MTC_REG_PWMCAP: pwmCap_q <= regWdata;
               default: begin
                  ctrl_q <= ctrl_q;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: dv/mtc_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mtc_pin_model (
   input  wire logic mclk,    // System clock.
   input  wire logic want,    // Level the bench asks for.
   output var  logic timerIn  // Driven timer input pin.
);
   logic [2:0] age = 3'h0;
   initial timerIn = 1'b0;
   // A change asked for too soon is held back, so edges stay four clocks apart.
   always @(posedge mclk) begin
      if (want != timerIn && age >= 3'h3) begin
         timerIn <= want;
         age <= 3'h0;
      end else if (age != 3'h7)
         age <= age + 3'h1;
   end
endmodule
`default_nettype wire

/* File: dv/mtc_timer_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module mtc_timer_assertions (
   input wire logic        mclk,     // System clock.
   input wire logic        reset_n,  // Synchronous reset.
   input wire logic        clkEn,    // Clock enable.
   input wire logic [2:0]  regAddr,  // Register index.
   input wire logic [15:0] regWdata, // Write data.
   input wire logic        regWr,    // Write strobe.
   input wire logic        regRd,    // Read strobe.
   input wire logic [15:0] regRdata, // Read data.
   input wire logic        timerIn,  // Timer input.
   input wire logic        timerOut, // Timer output.
   input wire logic        timerIrq  // Interrupt pulse.
);
   logic enQ;
   wire  ctlWr = clkEn && regWr && regAddr == 3'h0;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // Shadow of the enable bit, so that events can be tied to a running timer.
   always @(posedge mclk) begin
      if (!reset_n)
         enQ <= 1'b0;
      else if (ctlWr)
         enQ <= regWdata[0];
   end
   reset_quiet_a: assert property (disable iff (1'b0)
      !reset_n |=> !timerOut && !timerIrq && regRdata == 16'h0000) else $error("busy in reset");
   idle_rdata_a: assert property (clkEn && !regRd |=> regRdata == 16'h0000)
      else $error("read data without read");
   unmapped_a: assert property (clkEn && regRd && regAddr > 3'h4 |=> regRdata == 16'h0000)
      else $error("unmapped read not zero");
   ctrl_back_a: assert property (ctlWr ##1 (clkEn && regRd && regAddr == 3'h0)
      |=> regRdata == ($past(regWdata, 2) & 16'h7f3f)) else $error("control readback");
   reload_back_a: assert property ((clkEn && regWr && regAddr == 3'h2) ##1
      (clkEn && regRd && regAddr == 3'h2) |=> regRdata == $past(regWdata, 2))
      else $error("reload readback");
   disable_out_a: assert property (ctlWr && !regWdata[0] |=> timerOut == $past(regWdata[4]))
      else $error("output not at polarity");
   irq_enabled_a: assert property (timerIrq |-> $past(enQ))
      else $error("interrupt while stopped");
   out_cause_a: assert property ($changed(timerOut) |-> $past(enQ) || $past(ctlWr))
      else $error("output moved while stopped");
endmodule
bind mtc_timer mtc_timer_assertions i_mtc_timer_assertions (.mclk(mclk), .reset_n(reset_n),
   .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata(regRdata), .timerIn(timerIn), .timerOut(timerOut), .timerIrq(timerIrq));
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
   typedef struct {logic [2:0] a; logic [15:0] e;} mtc_row_t;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic        clkEn = 1'b1;
   logic [2:0]  regAddr = 3'h0;
   logic [15:0] regWdata = 16'h0000;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic        pinWant = 1'b0;
   logic [15:0] v;
   wire  [15:0] regRdata;
   wire         timerIn;
   wire         timerOut;
   wire         timerIrq;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   int          irqs = 0;
   int          lowRun = 0;
   int          lastLow = 0;
   int          k;
   mtc_row_t    rows [7] = '{'{3'h0, 16'h0000}, '{3'h1, 16'h0000}, '{3'h2, 16'hffff},
                             '{3'h3, 16'h0000}, '{3'h4, 16'h0000}, '{3'h5, 16'h0000},
                             '{3'h7, 16'h0000}};
   mtc_timer i_mtc_timer (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .timerIn(timerIn), .timerOut(timerOut), .timerIrq(timerIrq));
   mtc_pin_model i_mtc_pin_model (.mclk(mclk), .want(pinWant), .timerIn(timerIn));
   always #50 mclk = ~mclk;
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (timerIrq === 1'b1)
         irqs <= irqs + 1;
      if (timerOut === 1'b0)
         lowRun <= lowRun + 1;
      else begin
         lowRun <= 0;
         if (lowRun != 0)
            lastLow <= lowRun;
      end
      if (cycles == 5000) begin
         bad_count++;
         close_out();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic drv(input logic w, r, input logic [2:0] a, input logic [15:0] d);
      @(posedge mclk);
      regWr <= w;
      regRd <= r;
      regAddr <= a;
      regWdata <= d;
   endtask
   task automatic get(input logic [2:0] a);
      drv(1'b0, 1'b1, a, 16'h0000);
      drv(1'b0, 1'b0, 3'h0, 16'h0000);
      #1 v = regRdata;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      get(a);
      chk(v, e, "register");
   endtask
   task automatic pin(input logic l);
      @(posedge mclk);
      pinWant <= l;
      repeat (8) @(posedge mclk);
   endtask
   // Stopped first, then values, then the enable write last.
   task automatic cfg(input logic [15:0] c, cnt, pw, rl);
      drv(1'b1, 1'b0, 3'h0, c);
      rd(3'h0, c & 16'h7f3f);
      drv(1'b1, 1'b0, 3'h1, cnt);
      drv(1'b1, 1'b0, 3'h3, pw);
      drv(1'b1, 1'b0, 3'h2, rl);
      rd(3'h2, rl);
      chk(timerOut, c[4], "start level");
      drv(1'b1, 1'b0, 3'h0, c | 16'h0001);
      drv(1'b0, 1'b0, 3'h0, 16'h0000);
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      foreach (rows[i]) rd(rows[i].a, rows[i].e);
      drv(1'b1, 1'b0, 3'h0, 16'hffc0);
      rd(3'h0, 16'h7f00);
      cfg(16'h0030, 16'h0001, 16'h0000, 16'h0003);
      k = irqs;
      for (int i = 0; i < 2; i++) begin
         pin(1'b1);
         pin(1'b0);
      end
      rd(3'h1, 16'h0003);
      pin(1'b1);
      pin(1'b0);
      rd(3'h1, 16'h0001);
      chk(irqs - k, 16'h1, "irqs");
      chk(timerOut, 16'h0, "toggle");
      for (int p = 0; p < 2; p++) begin
         cfg(16'h0202 | (p << 4), 16'h0001, 16'h0002, 16'h0005);
         repeat (40) @(posedge mclk);
         chk(lastLow, (p ? 3 : 2) * 2, "low time");
      end
      cfg(16'h0126, 16'hfffe, 16'h0000, 16'h0001);
      k = irqs;
      repeat (10) @(posedge mclk);
      chk(irqs - k, 16'h1, "irqs");
      chk(timerOut, 16'h1, "toggle");
      rd(3'h4, 16'h0003);
      rd(3'h4, 16'h0001);
      cfg(16'h0114, 16'h0001, 16'h0000, 16'hffff);
      k = irqs;
      pin(1'b1);
      chk(irqs - k, 16'h1, "irqs");
      get(3'h3);
      chk(v != 16'h0000, 16'h1, "capture");
      k = v;
      get(3'h1);
      chk(v > k, 16'h1, "running");
      @(posedge mclk);
      clkEn <= 1'b0;
      pin(1'b0);
      clkEn <= 1'b1;
      cfg(16'h0138, 16'h0001, 16'h0000, 16'hffff);
      repeat (10) @(posedge mclk);
      rd(3'h1, 16'h0001);
      k = irqs;
      pin(1'b1);
      pin(1'b0);
      chk(irqs - k, 16'h1, "irqs");
      get(3'h1);
      k = v;
      chk(v > 16'h0001, 16'h1, "gated");
      repeat (10) @(posedge mclk);
      rd(3'h1, k);
      close_out();
   end
endmodule
`default_nettype wire
